// ==== verilog/msp_sequencer.sv ====
// Microprogram sequencer with pipeline register and an APB control port.
// Assumes a control store that answers within one clock period.
//
// Functional notes
// - Next address: repeat, return, next, or jump
// - Return stack holds four link addresses
// - Stack does hold, pop, push or load
// - Return selects stack; pop comes from the stack field
// - Sequencer bits: control, branch, conditional fields
// - Without condition, control field alone decides
// - Direct jump uses microword bits 0-11
// - Condition picks first or second select set
// - Test object chosen by earlier microinstruction
// - Interrupt jump disables map and vector
// - Vector jump: eight word bits, four vector
// - Vector selector has four sources
// - Interrupt taken only at map jump
// - Pipeline and address load same edge
// - Both load on rising clock edge
// - Fetch next word while current executes
// - Address register, stack, incrementer each cycle
`timescale 1ns/1ps
`default_nettype none
module msp_sequencer import msp_pkg::*; (
    // Clock, reset and enable
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic CE_I,
    // Control store
    input wire logic [UWORD_W-1:0] CSTORE_DATA_I,
    output logic [UADDR_W-1:0] UADDR_O,
    output logic [UWORD_W-1:0] PIPE_O,
    // Branch sources and conditions
    input wire logic [UADDR_W-1:0] MAP_ADDR_I,
    input wire logic [15:0] INSTR_WORD_I,
    input wire logic [VEC_W-1:0] FIRST_SRC_I,
    input wire logic [VEC_W-1:0] AUTOLOAD_I,
    input wire logic [TEST_W-1:0] TEST_OBJ_I,
    input wire logic INT_PENDING_I,
    input wire logic [IVEC_W-1:0] INT_VECTOR_I,
    output logic INT_ACK_O,
    // APB slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O
);
    logic [UADDR_W-1:0] uaddr_ff;
    logic [UWORD_W-1:0] pipe_ff;
    logic [TSEL_W-1:0] tsel_ff;
    logic halt_ff;
    logic int_en_ff;
    logic int_ack_ff;
    logic int_taken_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic adv;
    logic cond_true;
    logic [UADDR_W-1:0] uaddr_inc;
    logic [UADDR_W-1:0] nxt_uaddr;
    logic [UADDR_W-1:0] jump_addr;
    logic int_take;
    msp_src_e src;
    msp_stk_e stk_op;
    msp_bsrc_e bsrc;
    logic [UADDR_W-1:0] stk_top;
    logic [DEPTH_W-1:0] stk_depth;
    logic [VEC_W-1:0] vec;
    logic apb_access;
    logic apb_wr;

    // Known register offsets
    function automatic logic f_mapped(input logic [11:0] addr);
        f_mapped = (addr == OFS_CTRL) || (addr == OFS_STATUS) || (addr == OFS_STK_TOP);
    endfunction

    // Sequencer steps only when enabled and not halted by software
    assign adv = CE_I && !halt_ff;

    // Incrementer on the current micro address
    assign uaddr_inc = UADDR_W'(uaddr_ff + 1'b1);

    // Test object chosen by the select latched from an earlier word
    assign cond_true = TEST_OBJ_I[tsel_ff];

    // Pick the select set: the first one unless a false condition asks otherwise
    always_comb begin
        if (CSTORE_DATA_I[F_COND_EN] && !cond_true) begin
            src = msp_src_e'(CSTORE_DATA_I[F_SRC_F +: 2]);
            stk_op = msp_stk_e'(CSTORE_DATA_I[F_STK_F +: 2]);
        end else begin
            src = msp_src_e'(CSTORE_DATA_I[F_SRC_T +: 2]);
            stk_op = msp_stk_e'(CSTORE_DATA_I[F_STK_T +: 2]);
        end
    end

    // Branch address origin field of the microword
    assign bsrc = msp_bsrc_e'(CSTORE_DATA_I[F_BSRC +: 2]);

    // Interrupts break in only at a mapping jump
    assign int_take = (src == SRC_JUMP) && (bsrc == BSRC_MAP) && INT_PENDING_I
        && int_en_ff;

    // Vector selector for the low part of a vectored jump
    msp_vector_sel u_vsel (
        .sel_i(msp_vsel_e'(CSTORE_DATA_I[F_VSEL +: 2])),
        .instr_word_i(INSTR_WORD_I),
        .first_src_i(FIRST_SRC_I),
        .autoload_i(AUTOLOAD_I),
        .vec_o(vec)
    );

    // Jump address origin; map excludes vector, interrupt excludes both
    always_comb begin
        if (int_take) begin
            jump_addr = {INT_FIXED_CODE, INT_VECTOR_I};
        end else begin
            unique case (bsrc)
                BSRC_MAP: jump_addr = MAP_ADDR_I;
                BSRC_VECTOR: jump_addr = {CSTORE_DATA_I[F_BR_HI -: 8], vec};
                BSRC_WORD: jump_addr = CSTORE_DATA_I[F_BR_HI:F_BR_LO];
                BSRC_RSVD: jump_addr = CSTORE_DATA_I[F_BR_HI:F_BR_LO];
            endcase
        end
    end

    // Micro address register input multiplexer
    always_comb begin
        unique case (src)
            SRC_NEXT: nxt_uaddr = uaddr_inc;
            SRC_JUMP: nxt_uaddr = jump_addr;
            SRC_RETURN: nxt_uaddr = stk_top;
            SRC_REPEAT: nxt_uaddr = uaddr_ff;
        endcase
    end

    // Return stack; push and load store the address after the current one
    msp_ret_stack u_stack (
        .clk_i(CLK_I),
        .rst_b_i(RST_B_I),
        .en_i(adv),
        .op_i(stk_op),
        .data_i(uaddr_inc),
        .top_o(stk_top),
        .depth_o(stk_depth)
    );

    // Micro address and pipeline load on the same rising edge
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            uaddr_ff <= UADDR_RST;
            pipe_ff <= NOP_WORD;
        end else if (adv) begin
            uaddr_ff <= nxt_uaddr;
            pipe_ff <= CSTORE_DATA_I;
        end
    end

    // Test object select latched for a later testing word
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            tsel_ff <= '0;
        end else if (adv && CSTORE_DATA_I[F_TSEL_LD]) begin
            tsel_ff <= CSTORE_DATA_I[F_TSEL +: TSEL_W];
        end
    end

    // Interrupt acknowledge pulse and sticky taken flag; the event wins
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            int_ack_ff <= 1'b0;
            int_taken_ff <= 1'b0;
        end else if (CE_I) begin
            int_ack_ff <= adv && int_take;
            if (adv && int_take) begin
                int_taken_ff <= 1'b1;
            end else if (apb_wr && PADDR_I == OFS_STATUS && PWDATA_I[ST_INT_TAKEN]) begin
                int_taken_ff <= 1'b0;
            end
        end
    end

    // APB: one wait state, then the answer
    assign apb_access = PSEL_I && PENABLE_I && !pready_ff;
    assign apb_wr = PSEL_I && PENABLE_I && PWRITE_I && pready_ff && f_mapped(PADDR_I);

    // APB handshake and read data
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= '0;
        end else if (CE_I) begin
            pready_ff <= apb_access;
            pslverr_ff <= apb_access && !f_mapped(PADDR_I);
            prdata_ff <= '0;
            if (apb_access && !PWRITE_I) begin
                unique case (PADDR_I)
                    OFS_CTRL: prdata_ff <= {30'h0, int_en_ff, halt_ff};
                    OFS_STATUS: prdata_ff <= {11'h0, int_taken_ff, 1'b0, tsel_ff,
                        1'b0, stk_depth, uaddr_ff};
                    OFS_STK_TOP: prdata_ff <= {20'h0, stk_top};
                    default: prdata_ff <= '0;
                endcase
            end
        end
    end

    // Control register: halt and interrupt enable
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            halt_ff <= CTRL_RST[CTRL_HALT];
            int_en_ff <= CTRL_RST[CTRL_INT_EN];
        end else if (CE_I && apb_wr && PADDR_I == OFS_CTRL) begin
            halt_ff <= PWDATA_I[CTRL_HALT];
            int_en_ff <= PWDATA_I[CTRL_INT_EN];
        end
    end

    // Outputs straight from flip-flops
    assign UADDR_O = uaddr_ff;
    assign PIPE_O = pipe_ff;
    assign INT_ACK_O = int_ack_ff;
    assign PRDATA_O = prdata_ff;
    assign PREADY_O = pready_ff;
    assign PSLVERR_O = pslverr_ff;

    // Checks
    sequence s_call;
        adv && src != SRC_RETURN && stk_op == STK_PUSH;
    endsequence

    sequence s_ret;
        adv && src == SRC_RETURN && stk_op == STK_POP && stk_depth != '0;
    endsequence

    property p_jump_direct;
        @(posedge CLK_I) disable iff (!RST_B_I)
        adv && src == SRC_JUMP && bsrc == BSRC_WORD |=>
            UADDR_O == $past(CSTORE_DATA_I[F_BR_HI:F_BR_LO]);
    endproperty
    a_jump_direct: assert property (p_jump_direct) else $error("direct jump address wrong");

    property p_same_edge;
        @(posedge CLK_I) disable iff (!RST_B_I)
        adv |=> PIPE_O == $past(CSTORE_DATA_I) && UADDR_O == $past(nxt_uaddr);
    endproperty
    a_same_edge: assert property (p_same_edge) else $error("pipeline not loaded with address");

    property p_freeze;
        @(posedge CLK_I) disable iff (!RST_B_I)
        !adv |=> $stable(PIPE_O) && $stable(UADDR_O);
    endproperty
    a_freeze: assert property (p_freeze) else $error("pipeline moved without a clock step");

    property p_call_return;
        @(posedge CLK_I) disable iff (!RST_B_I)
        s_call ##1 (adv && src == SRC_NEXT && stk_op == STK_HOLD) ##1 s_ret |=>
            UADDR_O == UADDR_W'($past(uaddr_ff, 3) + 1'b1);
    endproperty
    a_call_return: assert property (p_call_return) else $error("return missed link");

    property p_push_top;
        @(posedge CLK_I) disable iff (!RST_B_I)
        adv && stk_op == STK_PUSH |=> stk_top == UADDR_W'($past(uaddr_ff) + 1'b1);
    endproperty
    a_push_top: assert property (p_push_top) else $error("push stored wrong link");

    property p_depth;
        @(posedge CLK_I) disable iff (!RST_B_I)
        stk_depth <= DEPTH_W'(STK_DEPTH);
    endproperty
    a_depth: assert property (p_depth) else $error("stack deeper than four");

    property p_int;
        @(posedge CLK_I) disable iff (!RST_B_I)
        adv && int_take |=> UADDR_O == {INT_FIXED_CODE, $past(INT_VECTOR_I)} && INT_ACK_O;
    endproperty
    a_int: assert property (p_int) else $error("interrupt vector wrong");

    property p_int_only_map;
        @(posedge CLK_I) disable iff (!RST_B_I)
        INT_ACK_O |-> $past(bsrc) == BSRC_MAP && $past(src) == SRC_JUMP;
    endproperty
    a_int_only_map: assert property (p_int_only_map) else $error("interrupt outside map jump");

    property p_map;
        @(posedge CLK_I) disable iff (!RST_B_I)
        adv && src == SRC_JUMP && bsrc == BSRC_MAP && !int_take |=>
            UADDR_O == $past(MAP_ADDR_I);
    endproperty
    a_map: assert property (p_map) else $error("map entry address wrong");

    property p_vector;
        @(posedge CLK_I) disable iff (!RST_B_I)
        adv && src == SRC_JUMP && bsrc == BSRC_VECTOR |=>
            UADDR_O == {$past(CSTORE_DATA_I[F_BR_HI -: 8]), $past(vec)};
    endproperty
    a_vector: assert property (p_vector) else $error("vectored address wrong");

    property p_repeat;
        @(posedge CLK_I) disable iff (!RST_B_I)
        adv && src == SRC_REPEAT |=> $stable(UADDR_O);
    endproperty
    a_repeat: assert property (p_repeat) else $error("repeat moved address");

    property p_next;
        @(posedge CLK_I) disable iff (!RST_B_I)
        adv && src == SRC_NEXT |=> UADDR_O == UADDR_W'($past(UADDR_O) + 1'b1);
    endproperty
    a_next: assert property (p_next) else $error("incrementer step wrong");
endmodule
`default_nettype wire

// ==== verilog/msp_pkg.sv ====
// Shared constants and types of the microprogram sequencer and pipeline.
// Assumes one clock domain; all users import the whole package.
package msp_pkg;

    // Widths of the micro address, microword and stack
    localparam int UADDR_W = 12;
    localparam int UWORD_W = 64;
    localparam int STK_DEPTH = 4;
    localparam int DEPTH_W = 3;
    localparam int TEST_W = 8;
    localparam int TSEL_W = 3;
    localparam int VEC_W = 4;
    localparam int IVEC_W = 5;

    // Microword field positions (sequencer part)
    localparam int F_BR_LO = 0;       // Branch address field, bits 0 to 11
    localparam int F_BR_HI = 11;
    localparam int F_SRC_T = 12;      // Next-address source, first set (2 bits)
    localparam int F_STK_T = 14;      // Stack operation, first set (2 bits)
    localparam int F_SRC_F = 16;      // Next-address source, second set
    localparam int F_STK_F = 18;      // Stack operation, second set
    localparam int F_COND_EN = 20;    // Condition enable
    localparam int F_TSEL = 21;       // Test object select (3 bits)
    localparam int F_TSEL_LD = 24;    // Load the test object select
    localparam int F_BSRC = 25;       // Branch address origin (2 bits)
    localparam int F_VSEL = 27;       // Vector selector source (2 bits)

    // Fixed upper part of an interrupt service vector
    localparam logic [UADDR_W-IVEC_W-1:0] INT_FIXED_CODE = 7'h7C;

    // Reset values
    localparam logic [UADDR_W-1:0] UADDR_RST = 12'h000;
    localparam logic [UWORD_W-1:0] NOP_WORD = 64'h0000_0000_0000_0000;
    localparam logic [31:0] CTRL_RST = 32'h0000_0002;

    // APB register offsets (byte addresses) and control fields
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_STK_TOP = 12'h008;
    localparam int CTRL_HALT = 0;
    localparam int CTRL_INT_EN = 1;
    localparam int ST_DEPTH_LO = 12;
    localparam int ST_TSEL_LO = 16;
    localparam int ST_INT_TAKEN = 20;

    // Next-address source
    typedef enum logic [1:0] {
        SRC_NEXT = 2'b00,
        SRC_JUMP = 2'b01,
        SRC_RETURN = 2'b10,
        SRC_REPEAT = 2'b11
    } msp_src_e;

    // Return stack operation
    typedef enum logic [1:0] {
        STK_HOLD = 2'b00,
        STK_POP = 2'b01,
        STK_PUSH = 2'b10,
        STK_LOAD = 2'b11
    } msp_stk_e;

    // Origin of a jump address
    typedef enum logic [1:0] {
        BSRC_WORD = 2'b00,
        BSRC_MAP = 2'b01,
        BSRC_VECTOR = 2'b10,
        BSRC_RSVD = 2'b11
    } msp_bsrc_e;

    // Vector selector sources
    typedef enum logic [1:0] {
        VSEL_MODE = 2'b00,
        VSEL_VARIANT = 2'b01,
        VSEL_FIRST_SRC = 2'b10,
        VSEL_AUTOLOAD = 2'b11
    } msp_vsel_e;

endpackage

// ==== verilog/msp_ret_stack.sv ====
// Four-entry push/pop return stack for micro subroutine linkage.
// Assumes the caller gives one operation per enabled clock edge.
`timescale 1ns/1ps
`default_nettype none
module msp_ret_stack import msp_pkg::*; (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic en_i,
    // Operation
    input wire msp_stk_e op_i,
    input wire logic [UADDR_W-1:0] data_i,
    // State
    output logic [UADDR_W-1:0] top_o,
    output logic [DEPTH_W-1:0] depth_o
);
    logic [UADDR_W-1:0] stk_ff [0:STK_DEPTH-1];
    logic [DEPTH_W-1:0] depth_ff;

    // Entries shift down on push and up on pop; entry 0 is the top
    for (genvar gi = 0; gi < STK_DEPTH; gi++) begin : g_ent
        logic [UADDR_W-1:0] above;
        logic [UADDR_W-1:0] below;
        if (gi == 0) begin : g_top
            assign above = data_i;
        end else begin : g_mid
            assign above = stk_ff[gi-1];
        end
        if (gi == STK_DEPTH-1) begin : g_bot
            assign below = stk_ff[gi];
        end else begin : g_up
            assign below = stk_ff[gi+1];
        end
        always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                stk_ff[gi] <= '0;
            end else if (en_i) begin
                unique case (op_i)
                    STK_HOLD: ;
                    STK_POP: stk_ff[gi] <= below;
                    STK_PUSH: stk_ff[gi] <= above;
                    STK_LOAD: if (gi == 0) stk_ff[gi] <= data_i;
                endcase
            end
        end
    end

    // Fill level: saturates when full, stays empty on an empty pop
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            depth_ff <= '0;
        end else if (en_i) begin
            unique case (op_i)
                STK_HOLD: ;
                STK_POP: if (depth_ff != '0) depth_ff <= DEPTH_W'(depth_ff - 1'b1);
                STK_PUSH: if (depth_ff != DEPTH_W'(STK_DEPTH)) depth_ff <= DEPTH_W'(depth_ff + 1'b1);
                STK_LOAD: if (depth_ff == '0) depth_ff <= DEPTH_W'(1);
            endcase
        end
    end

    assign top_o = stk_ff[0];
    assign depth_o = depth_ff;
endmodule
`default_nettype wire

// ==== verilog/msp_vector_sel.sv ====
// Vector selector: four-bit low part of a vectored jump address.
// Assumes its inputs are stable for the cycle in which they are used.
`timescale 1ns/1ps
`default_nettype none
module msp_vector_sel import msp_pkg::*; (
    // Selection from the microword
    input wire msp_vsel_e sel_i,
    // Sources
    input wire logic [15:0] instr_word_i,
    input wire logic [VEC_W-1:0] first_src_i,
    input wire logic [VEC_W-1:0] autoload_i,
    // Vector
    output logic [VEC_W-1:0] vec_o
);
    // One of four sources under microprogram control
    always_comb begin
        unique case (sel_i)
            VSEL_MODE: vec_o = {1'b0, instr_word_i[10:8]};
            VSEL_VARIANT: vec_o = instr_word_i[3:0];
            VSEL_FIRST_SRC: vec_o = first_src_i;
            VSEL_AUTOLOAD: vec_o = autoload_i;
        endcase
    end
endmodule
`default_nettype wire

// ==== verif/msp_cstore_model.sv ====
// Behavioural control store that sits in front of the sequencer.
// Assumes the bench owns the image and keeps it stable while running.
`timescale 1ns/1ps
`default_nettype none
module msp_cstore_model import msp_pkg::*; #(
    parameter int ACC_NS = 2
) (
    // Image and address
    input wire logic [UWORD_W-1:0] image_i [1<<UADDR_W],
    input wire logic [UADDR_W-1:0] addr_i,
    // Word read out
    output logic [UWORD_W-1:0] data_o
);
    // Access delay below one period, so the word settles before the rising edge
    assign #(ACC_NS) data_o = image_i[addr_i];
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking bench: runs a short microprogram, then pokes the APB port.
// Assumes one 200 MHz clock and the control store model beside the sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb_top import msp_pkg::*;;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    logic [UWORD_W-1:0] rom [1<<UADDR_W];
    logic [UWORD_W-1:0] cs_data, pipe;
    logic [UADDR_W-1:0] uaddr;
    logic [TEST_W-1:0] tobj = '0;
    logic intp = 1'b0;
    logic ack, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic er;
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;
    int acks = 0;
    logic [11:0] exp_a [15] = '{12'h010, 12'h020, 12'h021, 12'h011, 12'h011, 12'h011, 12'h030,
        12'h5A2, 12'h605, 12'h619, 12'h62C, 12'h123, 12'hF93, 12'hF94, 12'hF95};
    logic [14:0] tmask = 15'h0030;
    logic [14:0] imask = 15'h1780;

    // Clock
    always #2.5 clk = ~clk;

    msp_cstore_model u_rom (.image_i(rom), .addr_i(uaddr), .data_o(cs_data));

    msp_sequencer u_dut (
        .CLK_I(clk), .RST_B_I(rst_b), .CE_I(ce), .CSTORE_DATA_I(cs_data), .UADDR_O(uaddr),
        .PIPE_O(pipe), .MAP_ADDR_I(12'h123), .INSTR_WORD_I(16'h0A05), .FIRST_SRC_I(4'h9),
        .AUTOLOAD_I(4'hC), .TEST_OBJ_I(tobj), .INT_PENDING_I(intp), .INT_VECTOR_I(5'h13),
        .INT_ACK_O(ack), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr)
    );

    // Builds one microword from its sequencer fields
    function automatic logic [63:0] mw(input logic [1:0] s1, k1, s2, k2, input logic c,
        input logic [1:0] bs, vs, input logic [11:0] br);
        mw = '0;
        mw[F_BR_HI:F_BR_LO] = br;
        mw[F_SRC_T+:2] = s1;
        mw[F_STK_T+:2] = k1;
        mw[F_SRC_F+:2] = s2;
        mw[F_STK_F+:2] = k2;
        mw[F_COND_EN] = c;
        mw[F_BSRC+:2] = bs;
        mw[F_VSEL+:2] = vs;
    endfunction

    // Counts and reports one comparison
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; holds the request until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
        output logic [31:0] rdat, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // Sample the answer at rising edges only; the hang guard ends a lost wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Verdict and end of run
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    // Main sequence
    initial begin
        for (int j = 0; j < (1 << UADDR_W); j++) begin
            rom[j] = NOP_WORD;
        end
        rom[12'h000] = mw(SRC_JUMP, STK_HOLD, SRC_NEXT, STK_HOLD, 1'b0, BSRC_WORD, VSEL_MODE, 12'h010);
        rom[12'h010] = mw(SRC_JUMP, STK_PUSH, SRC_NEXT, STK_HOLD, 1'b0, BSRC_WORD, VSEL_MODE, 12'h020);
        rom[12'h020] = mw(SRC_NEXT, STK_HOLD, SRC_NEXT, STK_HOLD, 1'b0, BSRC_WORD, VSEL_MODE, 12'h000);
        // Select test object 3 ahead of the testing word
        rom[12'h020][F_TSEL_LD] = 1'b1;
        rom[12'h020][F_TSEL+:TSEL_W] = 3'h3;
        rom[12'h021] = mw(SRC_RETURN, STK_POP, SRC_NEXT, STK_HOLD, 1'b0, BSRC_WORD, VSEL_MODE, 12'h000);
        rom[12'h011] = mw(SRC_REPEAT, STK_HOLD, SRC_JUMP, STK_HOLD, 1'b1, BSRC_WORD, VSEL_MODE, 12'h030);
        rom[12'h030] = mw(SRC_JUMP, STK_HOLD, SRC_NEXT, STK_HOLD, 1'b0, BSRC_VECTOR, VSEL_MODE, 12'h5A0);
        rom[12'h5A2] = mw(SRC_JUMP, STK_HOLD, SRC_NEXT, STK_HOLD, 1'b0, BSRC_VECTOR, VSEL_VARIANT, 12'h600);
        rom[12'h605] = mw(SRC_JUMP, STK_HOLD, SRC_NEXT, STK_HOLD, 1'b0, BSRC_VECTOR, VSEL_FIRST_SRC, 12'h610);
        rom[12'h619] = mw(SRC_JUMP, STK_HOLD, SRC_NEXT, STK_HOLD, 1'b0, BSRC_VECTOR, VSEL_AUTOLOAD, 12'h620);
        rom[12'h62C] = mw(SRC_JUMP, STK_HOLD, SRC_NEXT, STK_HOLD, 1'b0, BSRC_MAP, VSEL_MODE, 12'h000);
        rom[12'h123] = mw(SRC_JUMP, STK_HOLD, SRC_NEXT, STK_HOLD, 1'b0, BSRC_MAP, VSEL_MODE, 12'h000);
        repeat (5) @(posedge clk);
        chk(uaddr, UADDR_RST);
        chk(pipe, NOP_WORD);
        rst_b <= 1'b1;
        // Each edge: drive test object and interrupt, then compare address and pipeline
        for (int i = 1; i <= 15; i++) begin
            @(posedge clk);
            tobj <= {4'h0, tmask[i % 15], 3'h0};
            intp <= imask[i % 15];
            #1;
            chk(uaddr, exp_a[i-1]);
            chk(pipe, rom[(i == 1) ? 12'h000 : exp_a[i-2]]);
            if (ack === 1'b1) begin
                acks++;
            end
        end
        chk(acks, 1);
        apb(1'b0, OFS_CTRL, 32'h0, rd, er);
        chk(rd, CTRL_RST);
        apb(1'b1, OFS_CTRL, 32'h0000_0003, rd, er);
        apb(1'b0, OFS_STATUS, 32'h0, rd, er);
        chk(rd[11:0], uaddr);
        chk({rd[20], rd[14:12]}, 4'h8);
        repeat (3) @(posedge clk);
        chk(rd[11:0], uaddr);
        apb(1'b0, 12'h00C, 32'h0, rd, er);
        chk({er, rd}, 33'h0_0000_0000 | (33'h1 << 32));
        apb(1'b1, OFS_CTRL, 32'h0000_0002, rd, er);
        @(posedge clk);
        #1;
        rd[11:0] = uaddr;
        @(posedge clk);
        #1;
        chk(uaddr, rd[11:0] + 12'h001);
        // Clock enable low: one more step, then address frozen for three edges
        rd[11:0] = uaddr;
        @(posedge clk);
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk(uaddr, rd[11:0] + 12'h001);
        @(posedge clk);
        ce <= 1'b1;
        tally_and_finish();
    end
endmodule
`default_nettype wire
